// [logic/adc_pkg.sv]
// Shared constants and types of the dual converter output control
package adc_pkg;

    // Data path shape
    localparam int RESULT_WIDTH = 12;
    localparam int LEVEL_WIDTH  = 14;
    localparam int PIPE_LATENCY = 5;
    localparam int CHANNELS     = 2;

    // Register port shape
    localparam int ADDR_WIDTH  = 4;
    localparam int DATA_WIDTH  = 32;
    localparam int EVENT_COUNT = 4;

    // Register offsets
    localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] MASK_ADDR   = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] STATE_ADDR  = 4'h8;

    // Status and mask bit positions, one bit per channel from the base
    localparam int EVENT_RANGE_BASE  = 0;
    localparam int EVENT_RESULT_BASE = 2;

    // State register fields
    localparam int STATE_POWER_LSB   = 0;
    localparam int POWER_FIELD_WIDTH = 2;
    localparam int STATE_TWOS_BIT    = 4;
    localparam int STATE_STAB_BIT    = 5;
    localparam int STATE_SELECT_BIT  = 6;

    // Reset values
    localparam logic [EVENT_COUNT-1:0]  STATUS_RESET = 4'h0;
    localparam logic [EVENT_COUNT-1:0]  MASK_RESET   = 4'h0;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
    localparam logic [DATA_WIDTH-1:0]   READ_IDLE    = 32'h0000_0000;

    // Offset binary code of a zero input level
    localparam logic [LEVEL_WIDTH-1:0] MID_SCALE = 14'h0800;

    // Four levels of the shared format pin, ground to full supply
    typedef enum logic [1:0] {
        level_ground,
        level_third,
        level_two_thirds,
        level_supply
    } format_level_type;

    // Per channel power and output state
    typedef enum logic [1:0] {
        power_driving,
        power_quiet,
        power_nap,
        power_sleep
    } power_type;

endpackage

// [logic/lane_if.sv]
// Signals between the output control and one conversion lane
`timescale 1ns/1ns
interface lane_if
    import adc_pkg::*;
#(
    parameter int WIDTH = RESULT_WIDTH,
    parameter int LEVEL = LEVEL_WIDTH
);
    logic             sample_edge;
    logic             run;
    logic [LEVEL-1:0] level;
    logic [WIDTH-1:0] result;
    logic             range_flag;
    logic             result_strobe;

    modport lane (
        input  sample_edge,
        input  run,
        input  level,
        output result,
        output range_flag,
        output result_strobe
    );
    modport ctrl (
        output sample_edge,
        output run,
        output level,
        input  result,
        input  range_flag,
        input  result_strobe
    );
endinterface

// [logic/conversion_lane.sv]
// One channel: capture on sample edge, fixed pipeline, saturating code
`timescale 1ns/1ns
module conversion_lane
    import adc_pkg::*;
#(
    parameter int WIDTH   = RESULT_WIDTH,
    parameter int LEVEL   = LEVEL_WIDTH,
    parameter int LATENCY = PIPE_LATENCY
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    lane_if.lane      port
);
    ////////////////////////////////////////////////////////////////////////
    if (LATENCY < 1 || LATENCY > 255 || LEVEL <= WIDTH) begin : g_check
        $error("conversion_lane: unsupported latency or widths");
    end

    typedef struct packed {
        logic [LATENCY-1:0][WIDTH-1:0] code;
        logic [LATENCY-1:0]            over;
        logic [WIDTH-1:0]              result;
        logic                          range_flag;
        logic                          strobe;
    } lane_state_type;

    lane_state_type state;
    lane_state_type next_state;

    // Level is signed around mid scale; out of range saturates the code
    function automatic logic [WIDTH:0] convert(input logic [LEVEL-1:0] lv);
        logic [LEVEL-1:0] shifted;
        shifted = lv + MID_SCALE;
        if ($signed(lv) >= $signed(MID_SCALE)) begin
            convert = {1'b1, {WIDTH{1'b1}}};
        end else if ($signed(lv) < -$signed(MID_SCALE)) begin
            convert = {1'b1, {WIDTH{1'b0}}};
        end else begin
            convert = {1'b0, shifted[WIDTH-1:0]};
        end
    endfunction

    logic [WIDTH:0] fresh;
    assign fresh = convert(port.level);

    // Whole pipe moves only on a sample edge of a running channel
    always_comb begin
        next_state = state;
        next_state.strobe = 1'b0;
        if (port.sample_edge && port.run) begin
            next_state.code[0] = fresh[WIDTH-1:0];
            next_state.over[0] = fresh[WIDTH];
            for (int i = 1; i < LATENCY; i++) begin
                next_state.code[i] = state.code[i-1];
                next_state.over[i] = state.over[i-1];
            end
            next_state.result     = state.code[LATENCY-1];
            next_state.range_flag = state.over[LATENCY-1];
            next_state.strobe     = 1'b1;
        end
    end

    // All state in one register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign port.result        = state.result;
    assign port.range_flag    = state.range_flag;
    assign port.result_strobe = state.strobe;

    ////////////////////////////////////////////////////////////////////////
    // Probe follows one sample through the pipe for the checks below
    logic [WIDTH:0] probe_code;
    logic           probe_busy;
    logic [7:0]     probe_count;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            probe_code  <= '0;
            probe_busy  <= 1'b0;
            probe_count <= 8'h00;
        end else if (port.sample_edge && port.run) begin
            if (!probe_busy) begin
                probe_code  <= fresh;
                probe_busy  <= 1'b1;
                probe_count <= 8'h00;
            end else if (probe_count == 8'(LATENCY - 1)) begin
                probe_busy <= 1'b0;
            end else begin
                probe_count <= probe_count + 8'h01;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    capture_strobe_a: assert property (
        (port.sample_edge && port.run) |=> port.result_strobe ##1
        !port.result_strobe || $past(port.sample_edge && port.run))
        else $error("sample edge did not move the pipe");
    idle_pipe_a: assert property (
        !(port.sample_edge && port.run) |=> !port.result_strobe)
        else $error("pipe moved without a sample edge");
    pipe_latency_a: assert property (
        probe_busy && probe_count == 8'(LATENCY - 1) && port.sample_edge
        && port.run |=> port.result == probe_code[WIDTH-1:0])
        else $error("result not out after the pipeline latency");
    range_flag_a: assert property (
        probe_busy && probe_count == 8'(LATENCY - 1) && port.sample_edge
        && port.run |=> port.range_flag == probe_code[WIDTH])
        else $error("range flag does not match the sample");
    range_seen_c: cover property (
        port.result_strobe && port.range_flag);
endmodule

// [logic/event_registers.sv]
// Sticky event status, mask, state readback and interrupt level
`timescale 1ns/1ns
module event_registers
    import adc_pkg::*;
#(
    parameter int EVENTS = EVENT_COUNT
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    input  wire logic [EVENTS-1:0]     event_set,
    input  wire logic [DATA_WIDTH-1:0] state_word,
    output logic      [DATA_WIDTH-1:0] reg_rdata,
    output logic                       irq
);
    ////////////////////////////////////////////////////////////////////////
    if (EVENTS < 1 || EVENTS > DATA_WIDTH) begin : g_check
        $error("event_registers: event count does not fit a word");
    end

    typedef struct packed {
        logic [EVENTS-1:0]     status;
        logic [EVENTS-1:0]     mask;
        logic [DATA_WIDTH-1:0] rdata;
    } reg_state_type;

    reg_state_type state;
    reg_state_type next_state;

    // Write one clears; a same-cycle event wins over the clear
    always_comb begin
        next_state = state;
        next_state.rdata = READ_IDLE;
        if (reg_write && reg_addr == STATUS_ADDR) begin
            next_state.status = state.status & ~reg_wdata[EVENTS-1:0];
        end
        if (reg_write && reg_addr == MASK_ADDR) begin
            next_state.mask = reg_wdata[EVENTS-1:0];
        end
        next_state.status = next_state.status | event_set;
        if (reg_read) begin
            unique case (reg_addr)
                STATUS_ADDR: next_state.rdata = DATA_WIDTH'(state.status);
                MASK_ADDR:   next_state.rdata = DATA_WIDTH'(state.mask);
                STATE_ADDR:  next_state.rdata = state_word;
                default:     next_state.rdata = READ_IDLE;
            endcase
        end
    end

    // All state in one register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '{status: STATUS_RESET, mask: MASK_RESET,
                       rdata: READ_IDLE};
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign irq       = |(state.status & state.mask);
endmodule

// [logic/dual_adc_output_control.sv]
// Output routing, power states and format control of a dual converter
// What this block does
// - Each channel samples on the rising edge of its own independent clock.
// - Bus select high: channel first to bus first, second to bus second.
// - Bus select low: channels swap buses, flags travel with their results.
// - Shutdown low converts; outputs driven when enable low, else released.
// - Shutdown high gives nap or sleep by enable; outputs released both.
// - A channel's enable governs only that channel's own outputs.
// - One format input sets code format and stabilizer for both channels.
// - Ground, third, two thirds, supply: OB off, OB on, 2C on, 2C off.
// - Range flag high when the result went above or below full scale.
// - Bus second carries twelve result bits, bit eleven most significant.
// - Bus first carries twelve result bits, bit eleven most significant.
// - A sample appears on the bus five sample clocks after its edge.
`timescale 1ns/1ns
module dual_adc_output_control
    import adc_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    sample_clock_first,
    input  wire logic                    sample_clock_second,
    input  wire logic [LEVEL_WIDTH-1:0]  sample_level_first,
    input  wire logic [LEVEL_WIDTH-1:0]  sample_level_second,
    input  wire logic                    bus_select,
    input  wire logic                    power_down_first,
    input  wire logic                    power_down_second,
    input  wire logic                    output_enable_n_first,
    input  wire logic                    output_enable_n_second,
    input  wire logic [1:0]              format_select,
    output logic      [RESULT_WIDTH-1:0] result_bus_first,
    output logic                         range_flag_first,
    output logic                         result_bus_first_oe,
    output logic      [RESULT_WIDTH-1:0] result_bus_second,
    output logic                         range_flag_second,
    output logic                         result_bus_second_oe,
    output logic                         stabilizer_on,
    input  wire logic [ADDR_WIDTH-1:0]   reg_addr,
    input  wire logic [DATA_WIDTH-1:0]   reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [DATA_WIDTH-1:0]   reg_rdata,
    output logic                         irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic      [CHANNELS-1:0]                   prev_clock;
        logic      [CHANNELS-1:0][RESULT_WIDTH-1:0] bus_data;
        logic      [CHANNELS-1:0]                   bus_flag;
        logic      [CHANNELS-1:0]                   bus_oe;
        logic                                       twos;
        logic                                       stab;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;

    logic [CHANNELS-1:0]                   clock_pin;
    logic [CHANNELS-1:0]                   power_pin;
    logic [CHANNELS-1:0]                   enable_n_pin;
    logic [CHANNELS-1:0][LEVEL_WIDTH-1:0]  level_pin;
    logic [CHANNELS-1:0]                   sample_edge;
    logic [CHANNELS-1:0]                   run;
    logic [CHANNELS-1:0]                   drive;
    logic [CHANNELS-1:0][RESULT_WIDTH-1:0] lane_result;
    logic [CHANNELS-1:0]                   lane_flag;
    logic [CHANNELS-1:0]                   lane_strobe;
    logic                                  twos_select;
    logic                                  stab_select;
    logic [EVENT_COUNT-1:0]                event_set;
    logic [DATA_WIDTH-1:0]                 state_word;
    power_type                             power_state [CHANNELS];

    // Pins gathered per channel, index 0 is the first channel
    assign clock_pin    = {sample_clock_second, sample_clock_first};
    assign power_pin    = {power_down_second, power_down_first};
    assign enable_n_pin = {output_enable_n_second, output_enable_n_first};
    assign level_pin    = {sample_level_second, sample_level_first};

    // Clocks are plain inputs here, so a rising edge is a one-cycle pulse
    assign sample_edge = clock_pin & ~state.prev_clock;
    assign run         = ~power_pin;
    assign drive       = ~power_pin & ~enable_n_pin;

    // One pin sets both channels; stabilizer only at the middle levels
    assign twos_select = format_select inside {level_two_thirds,
                                               level_supply};
    assign stab_select = format_select inside {level_third,
                                               level_two_thirds};

    ////////////////////////////////////////////////////////////////////////
    // One lane per channel, each paced by its own sample clock
    lane_if lanes [CHANNELS] ();

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_lane
        assign lanes[ch].sample_edge = sample_edge[ch];
        assign lanes[ch].run         = run[ch];
        assign lanes[ch].level       = level_pin[ch];
        assign lane_result[ch]       = lanes[ch].result;
        assign lane_flag[ch]         = lanes[ch].range_flag;
        assign lane_strobe[ch]       = lanes[ch].result_strobe;

        conversion_lane #(
            .WIDTH   (RESULT_WIDTH),
            .LEVEL   (LEVEL_WIDTH),
            .LATENCY (PIPE_LATENCY)
        ) u_lane (
            .clk     (clk),
            .sys_rst (sys_rst),
            .port    (lanes[ch])
        );

        // Nap keeps bias up for a quick wake; sleep drops nearly all
        always_comb begin
            if (power_pin[ch]) begin
                power_state[ch] = enable_n_pin[ch] ? power_sleep
                                                   : power_nap;
            end else begin
                power_state[ch] = enable_n_pin[ch] ? power_quiet
                                                   : power_driving;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Route, format and enable each bus from the channel it carries
    always_comb begin
        int src;
        src = 0;
        next_state            = state;
        next_state.prev_clock = clock_pin;
        next_state.twos       = twos_select;
        next_state.stab       = stab_select;
        for (int b = 0; b < CHANNELS; b++) begin
            src = bus_select ? b : CHANNELS - 1 - b;
            next_state.bus_data[b] = lane_result[src];
            if (twos_select) begin
                next_state.bus_data[b][RESULT_WIDTH-1] =
                    ~lane_result[src][RESULT_WIDTH-1];
            end
            next_state.bus_flag[b] = lane_flag[src];
            // Enable follows the channel, not the bus
            next_state.bus_oe[b]   = drive[src];
        end
    end

    // All state in one register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Registered outputs, so the bus never glitches on a select change
    assign result_bus_first     = state.bus_data[0];
    assign range_flag_first     = state.bus_flag[0];
    assign result_bus_first_oe  = state.bus_oe[0];
    assign result_bus_second    = state.bus_data[1];
    assign range_flag_second    = state.bus_flag[1];
    assign result_bus_second_oe = state.bus_oe[1];
    assign stabilizer_on        = state.stab;

    ////////////////////////////////////////////////////////////////////////
    // Events per channel: out of range result, and any new result
    assign event_set = {lane_strobe, lane_strobe & lane_flag};

    always_comb begin
        state_word = READ_IDLE;
        for (int ch = 0; ch < CHANNELS; ch++) begin
            state_word[STATE_POWER_LSB + ch*POWER_FIELD_WIDTH +:
                       POWER_FIELD_WIDTH] = power_state[ch];
        end
        state_word[STATE_TWOS_BIT]   = state.twos;
        state_word[STATE_STAB_BIT]   = state.stab;
        state_word[STATE_SELECT_BIT] = bus_select;
    end

    event_registers #(
        .EVENTS (EVENT_COUNT)
    ) u_regs (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_write  (reg_write),
        .reg_read   (reg_read),
        .event_set  (event_set),
        .state_word (state_word),
        .reg_rdata  (reg_rdata),
        .irq        (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    route_straight_a: assert property (
        bus_select && !twos_select |=>
        result_bus_first == $past(lane_result[0]) &&
        result_bus_second == $past(lane_result[1]) &&
        range_flag_first == $past(lane_flag[0]))
        else $error("straight routing wrong");
    route_swap_a: assert property (
        !bus_select && !twos_select |=>
        result_bus_first == $past(lane_result[1]) &&
        result_bus_second == $past(lane_result[0]) &&
        range_flag_second == $past(lane_flag[0]))
        else $error("swapped routing wrong");
    twos_msb_a: assert property (
        bus_select && twos_select |=>
        result_bus_first[RESULT_WIDTH-1] !=
            $past(lane_result[0][RESULT_WIDTH-1]) &&
        result_bus_first[RESULT_WIDTH-2:0] ==
            $past(lane_result[0][RESULT_WIDTH-2:0]))
        else $error("two's complement top bit not inverted");
    shutdown_hiz_a: assert property (
        power_down_first && !bus_select |=>
        !result_bus_second_oe && !lanes[0].result_strobe)
        else $error("shut down channel still drives or converts");
    drive_enabled_a: assert property (
        !power_down_first && bus_select |=>
        result_bus_first_oe == !$past(output_enable_n_first))
        else $error("normal channel enable wrong");
    own_enable_a: assert property (
        !power_down_second && !output_enable_n_second && !bus_select
        |=> result_bus_first_oe ##1 1'b1)
        else $error("enable disturbed by the other channel");
    mode_decode_a: assert property (
        ##1 stabilizer_on == ($past(format_select) == level_third ||
                              $past(format_select) == level_two_thirds))
        else $error("stabilizer level decode wrong");
    irq_level_a: assert property (
        $rose(irq) |-> $past(|event_set) || $past(reg_write))
        else $error("interrupt rose without a cause");

    swap_seen_c: cover property (
        !bus_select ##1 result_bus_second_oe && result_bus_first_oe);
    nap_seen_c: cover property (
        power_down_first && !output_enable_n_first ##1
        !result_bus_first_oe);
    twos_seen_c: cover property (
        twos_select && lane_strobe[0] ##1 stabilizer_on);
endmodule

// [verification/bus_capture.sv]
// Capture side model: latches bus first on its routed channel clock
`timescale 1ns/1ns
module bus_capture
    import adc_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    sample_clock_first,
    input  wire logic                    sample_clock_second,
    input  wire logic                    bus_select,
    input  wire logic [RESULT_WIDTH-1:0] result_bus_first,
    input  wire logic                    result_bus_first_oe,
    output logic      [RESULT_WIDTH-1:0] held_first
);
    ////////////////////////////////////////////////////////////////////
    // Swapped routing moves bus first onto the second channel clock
    always_ff @(posedge clk) begin
        if ((bus_select ? sample_clock_first : sample_clock_second)
            && result_bus_first_oe)
            held_first <= result_bus_first;
    end
endmodule

// [verification/tb.sv]
// Bench of the dual converter output control
`timescale 1ns/1ns
module tb;
    import adc_pkg::*;
    logic                    clk, sys_rst, ck1, ck2, sel, pd1, pd2, on1, on2;
    logic [LEVEL_WIDTH-1:0]  lv1, lv2;
    logic [1:0]              fmt;
    logic [RESULT_WIDTH-1:0] bus1, bus2, held;
    logic                    fl1, fl2, en1, en2, stab, wr, rd, irq;
    logic [ADDR_WIDTH-1:0]   addr;
    logic [DATA_WIDTH-1:0]   wdata, rdata, d;
    int                      fail_count = 0, compares = 0, cycles = 0;

    dual_adc_output_control i_dual_adc_output_control (
        .clk(clk), .sys_rst(sys_rst), .sample_clock_first(ck1),
        .sample_clock_second(ck2), .sample_level_first(lv1),
        .sample_level_second(lv2), .bus_select(sel),
        .power_down_first(pd1), .power_down_second(pd2),
        .output_enable_n_first(on1), .output_enable_n_second(on2),
        .format_select(fmt), .result_bus_first(bus1),
        .range_flag_first(fl1), .result_bus_first_oe(en1),
        .result_bus_second(bus2), .range_flag_second(fl2),
        .result_bus_second_oe(en2), .stabilizer_on(stab),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
        .reg_read(rd), .reg_rdata(rdata), .irq(irq));
    bus_capture i_bus_capture (
        .clk(clk), .sample_clock_first(ck1), .sample_clock_second(ck2),
        .bus_select(sel), .result_bus_first(bus1),
        .result_bus_first_oe(en1), .held_first(held));

    ////////////////////////////////////////////////////////////////////
    // Clock and a hang guard well above the expected run length
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Offset binary with saturation; two's complement flips the top bit
    function automatic logic [11:0] code(int l, bit twos);
        logic [11:0] c;
        c = l > 2047 ? 12'hFFF : l < -2048 ? 12'h000 : 12'(l + 2048);
        return {c[11] ^ twos, c[10:0]};
    endfunction
    // Each pulse is high one clk and low one clk, the tightest spacing
    task automatic edges(int n);
        repeat (n) begin
            @(posedge clk);
            ck1 <= 1'b1;
            ck2 <= 1'b1;
            @(posedge clk);
            ck1 <= 1'b0;
            ck2 <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(logic [3:0] a, logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {ck1, ck2, pd1, pd2, on1, on2, fmt, wr, rd, addr, wdata} = '0;
        sel = 1'b1;
        lv1 = 14'(100);
        lv2 = -14'(300);
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        edges(7);
        check("bus1", bus1, code(100, 0));
        check("bus2", bus2, code(-300, 0));
        check("held", held, code(100, 0));
        lv1 <= 14'(1000);
        edges(1);
        lv1 <= 14'(100);
        edges(4);
        check("early", bus1, code(100, 0));
        edges(1);
        check("late", bus1, code(1000, 0));
        $display("latency done");
        sel <= 1'b0;
        edges(0);
        check("swap1", bus1, code(-300, 0));
        check("swap2", bus2, code(1000, 0));
        sel <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            fmt <= 2'(f);
            edges(0);
            edges(0);
            check("stab", stab, f == 1 || f == 2);
            check("fmt1", bus1, code(1000, f > 1));
            check("fmt2", bus2, code(-300, f > 1));
        end
        fmt <= 2'h0;
        lv1 <= 14'(2048);
        lv2 <= -14'(2049);
        edges(6);
        check("over", {fl1, bus1}, {1'b1, 12'hFFF});
        check("under", {fl2, bus2}, {1'b1, 12'h000});
        $display("format and range done");
        for (int p = 0; p < 4; p++) begin
            {pd1, on1} <= 2'(p);
            edges(0);
            edges(0);
            check("en1", en1, p == 0);
            check("en2", en2, 1'b1);
        end
        // Swapped routing: a sleeping first channel releases bus second
        {sel, pd1} <= 2'h1;
        edges(0);
        edges(0);
        check("swap off", {en1, en2}, 2'h2);
        {sel, pd1, on1} <= 3'h4;
        reg_rd(STATUS_ADDR);
        check("status", d, 32'h0000_000F);
        reg_wr(STATUS_ADDR, 32'h0000_000F);
        reg_rd(STATUS_ADDR);
        check("cleared", d, 32'h0000_0000);
        reg_wr(MASK_ADDR, 32'h0000_0004);
        check("irq off", irq, 1'b0);
        edges(1);
        check("irq on", irq, 1'b1);
        reg_rd(4'hC);
        check("unmapped", d, 32'h0000_0000);
        reg_rd(STATE_ADDR);
        check("state", d, 32'h0000_0040);
        $display("power and registers done");
        stop_test();
    end
endmodule
